// ### logic/pxs_top.sv
// Purpose: 28-bit parallel to four-lane 7:1 serial pixel transmitter.
// Assumes: link_clk is a free-running 7x bit clock; pins are asynchronous.
// Notes:   Outputs are pos/neg/oe triples; oe low means high impedance.
module pxs_top (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        link_clk,
   input  wire logic        power_down_n,
   input  wire logic        capture_edge_select,
   input  wire logic        pixel_clock_in,
   input  wire logic [27:0] parallel_pixel_bits,
   output wire logic        lane0_pos,
   output wire logic        lane0_neg,
   output wire logic        lane0_oe,
   output wire logic        lane1_pos,
   output wire logic        lane1_neg,
   output wire logic        lane1_oe,
   output wire logic        lane2_pos,
   output wire logic        lane2_neg,
   output wire logic        lane2_oe,
   output wire logic        lane3_pos,
   output wire logic        lane3_neg,
   output wire logic        lane3_oe,
   output wire logic        fwd_clock_pos,
   output wire logic        fwd_clock_neg,
   output wire logic        fwd_clock_oe
);
   // ************************************************************
   // Reference domain state
   // ************************************************************
   typedef struct packed {
      logic [2:0] pd_sync;
      logic       run;
   } pxs_ref_state_t;

   // ************************************************************
   // Link domain state
   // ************************************************************
   typedef struct packed {
      logic [1:0]        run_sync;
      logic [2:0]        pclk_sync;
      logic [2:0]        sel_sync;
      logic [27:0]       data_s1;
      logic [27:0]       data_s2;
      logic [27:0]       data_s3;
      logic              pclk_stable;
      logic              sel_stable;
      logic [27:0]       word;
      logic              load;
      logic [2:0]        slot;
      pxs_pkg::pxs_mode_t mode;
      logic [4:0]        tx;
      logic              oe;
   } pxs_link_state_t;

   logic [1:0]      rst_ref_q;
   logic [1:0]      rst_lnk_q;
   pxs_ref_state_t  ref_d;
   pxs_ref_state_t  ref_q;
   pxs_link_state_t lnk_d;
   pxs_link_state_t lnk_q;
   logic            pclk_change;
   logic            capture;
   logic            lnk_clear;

   pxs_ser_if ser ();

   // ************************************************************
   // Reset release, one chain per domain
   // ************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_ref_q <= 2'h0;
      end else begin
         rst_ref_q <= {rst_ref_q[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         rst_lnk_q <= 2'h0;
      end else begin
         rst_lnk_q <= {rst_lnk_q[0], 1'b1};
      end
   end

   // ************************************************************
   // Power-down pin filter
   // ************************************************************
   // Level only changes once stages two and three agree
   always_comb begin
      ref_d = ref_q;
      ref_d.pd_sync = {ref_q.pd_sync[1:0], power_down_n};
      if (ref_q.pd_sync[1] == ref_q.pd_sync[2]) begin
         ref_d.run = ref_q.pd_sync[2];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_ref_q[1]) begin
      if (!rst_ref_q[1]) begin
         ref_q <= '0;
      end else begin
         ref_q <= ref_d;
      end
   end

   // ************************************************************
   // Link side: capture, slot counter, output stage
   // ************************************************************
   assign lnk_clear = !lnk_q.run_sync[1];

   assign pclk_change = (lnk_q.pclk_sync[1] == lnk_q.pclk_sync[2]) &&
                        (lnk_q.pclk_sync[2] != lnk_q.pclk_stable);

   // Rising edge when the new level is high, falling when low
   assign capture = pclk_change &&
                    (lnk_q.pclk_sync[2] == lnk_q.sel_stable);

   always_comb begin
      lnk_d = lnk_q;
      lnk_d.run_sync = {lnk_q.run_sync[0], ref_q.run};
      lnk_d.load = 1'b0;
      if (lnk_clear) begin
         // The run_sync stages keep running so release can be seen
         lnk_d = '0;
         lnk_d.run_sync = {lnk_q.run_sync[0], ref_q.run};
         lnk_d.mode = pxs_pkg::PXS_OFF;
      end else begin
         lnk_d.pclk_sync = {lnk_q.pclk_sync[1:0], pixel_clock_in};
         lnk_d.sel_sync = {lnk_q.sel_sync[1:0], capture_edge_select};
         // Data delayed to line up with the filtered pixel clock
         lnk_d.data_s1 = parallel_pixel_bits;
         lnk_d.data_s2 = lnk_q.data_s1;
         lnk_d.data_s3 = lnk_q.data_s2;
         if (pclk_change) begin
            lnk_d.pclk_stable = lnk_q.pclk_sync[2];
         end
         if (lnk_q.sel_sync[1] == lnk_q.sel_sync[2]) begin
            lnk_d.sel_stable = lnk_q.sel_sync[2];
         end
         if (capture) begin
            lnk_d.word = lnk_q.data_s3;
         end
         lnk_d.oe = 1'b1;
         lnk_d.tx = ser.bits;
         case (lnk_q.mode)
            pxs_pkg::PXS_OFF: begin
               lnk_d.mode = pxs_pkg::PXS_ARM;
            end
            pxs_pkg::PXS_ARM: begin
               if (capture) begin
                  lnk_d.load = 1'b1;
                  lnk_d.word = lnk_q.data_s3;
                  lnk_d.slot = pxs_pkg::SLOT_FIRST;
                  lnk_d.mode = pxs_pkg::PXS_RUN;
               end
            end
            pxs_pkg::PXS_RUN: begin
               // Seven bit times per word; latest capture is sent
               if (lnk_q.slot == pxs_pkg::SLOT_LAST) begin
                  lnk_d.slot = pxs_pkg::SLOT_FIRST;
                  lnk_d.load = 1'b1;
                  if (capture) begin
                     lnk_d.word = lnk_q.data_s3;
                  end
               end else begin
                  lnk_d.slot = lnk_q.slot + 3'h1;
               end
            end
            default: begin
               lnk_d.mode = pxs_pkg::PXS_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_lnk_q[1]) begin
      if (!rst_lnk_q[1]) begin
         lnk_q <= '0;
      end else begin
         lnk_q <= lnk_d;
      end
   end

   assign ser.load = lnk_q.load;
   assign ser.word = lnk_q.word;

   pxs_shifter u_shifter (
      .clk   (link_clk),
      .rst_n (rst_lnk_q[1]),
      .clear (lnk_clear),
      .ser   (ser.shift)
   );

   // ************************************************************
   // Pins: drivers disabled while powered down
   // ************************************************************
   // Lane 3 is driven whenever the other lanes are; an 18-bit receiver may ignore it
   assign lane0_pos     = lnk_q.tx[0];
   assign lane0_neg     = !lnk_q.tx[0];
   assign lane0_oe      = lnk_q.oe;
   assign lane1_pos     = lnk_q.tx[1];
   assign lane1_neg     = !lnk_q.tx[1];
   assign lane1_oe      = lnk_q.oe;
   assign lane2_pos     = lnk_q.tx[2];
   assign lane2_neg     = !lnk_q.tx[2];
   assign lane2_oe      = lnk_q.oe;
   assign lane3_pos     = lnk_q.tx[3];
   assign lane3_neg     = !lnk_q.tx[3];
   assign lane3_oe      = lnk_q.oe;
   assign fwd_clock_pos = lnk_q.tx[4];
   assign fwd_clock_neg = !lnk_q.tx[4];
   assign fwd_clock_oe  = lnk_q.oe;
endmodule

// ### logic/pxs_pkg.sv
// Purpose: Shared constants and types of the 7:1 pixel serializer.
// Assumes: link_clk runs at seven times the pixel clock rate.
// Notes:   Lane k carries word bits [7k+6:7k], lowest bit first.
//
// Operation
// - While power_down_n is low all data lane outputs are high impedance.
// - Forwarded pixel clock is driven, and high impedance while powered down.
// - Power down gives low power and resets registers; hold high to transmit.
// - capture_edge_select high captures on rising pixel edge, low on falling.
// - Power down stops shifting activity and disables output drivers.
// - While powered down every lnk_q and shifter register is cleared to zero.
package pxs_pkg;
   localparam int          LANE_CNT    = 4;
   localparam int          SER_CNT     = 5;
   localparam int          BIT_CNT     = 7;
   localparam int          WORD_W      = 28;
   localparam logic [6:0]  FWD_PATTERN = 7'h63;
   localparam logic [2:0]  SLOT_FIRST  = 3'h0;
   localparam logic [2:0]  SLOT_LAST   = 3'h6;
   localparam logic [27:0] WORD_RST    = 28'h0000000;
   localparam logic [1:0]  RST_SYNC_ON = 2'h3;

   typedef enum logic [1:0] {
      PXS_OFF = 2'b00,
      PXS_ARM = 2'b01,
      PXS_RUN = 2'b10
   } pxs_mode_t;
endpackage

// ### logic/pxs_ser_if.sv
// Purpose: Carries load strobe and word to the shifter, serial bits back.
// Assumes: Both ends run on link_clk.
// Notes:   bits[4] is the forwarded clock lane.
interface pxs_ser_if;
   logic        load;
   logic [27:0] word;
   logic [4:0]  bits;

   modport ctrl  (output load, output word, input bits);
   modport shift (input load, input word, output bits);
endinterface

// ### logic/pxs_shifter.sv
// Purpose: Four 7-bit parallel-load shift registers plus clock lane.
// Assumes: load arrives once every seven link_clk cycles.
// Notes:   clear zeroes all shift state synchronously.
module pxs_shifter (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clear,
   pxs_ser_if.shift  ser
);
   typedef struct packed {
      logic [4:0][6:0] sh;
   } pxs_shift_state_t;

   pxs_shift_state_t state_d;
   pxs_shift_state_t state_q;
   logic [4:0][6:0]  lane_src;

   // ************************************************************
   // Per-lane load source and serial tap
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < pxs_pkg::SER_CNT; g++) begin : g_lane
         if (g < pxs_pkg::LANE_CNT) begin : g_data
            assign lane_src[g] = ser.word[g*7 +: 7];
         end else begin : g_clk
            assign lane_src[g] = pxs_pkg::FWD_PATTERN;
         end
         assign ser.bits[g] = state_q.sh[g][0];
      end
   endgenerate

   always_comb begin
      state_d = state_q;
      if (clear) begin
         state_d = '0;
      end else if (ser.load) begin
         state_d.sh = lane_src;
      end else begin
         for (int k = 0; k < pxs_pkg::SER_CNT; k++) begin
            state_d.sh[k] = {1'b0, state_q.sh[k][6:1]};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end
endmodule

// ### tb/pxs_properties.sv
// Purpose: Pin checks of the serializer, bound to its top module.
// Assumes: link_clk runs at seven times the pixel clock.
// Notes:   A disabled pos pin reads low and a neg pin high; oe carries the driver state.
module pxs_properties (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic power_down_n,
   input wire logic lane0_pos,
   input wire logic lane1_pos,
   input wire logic lane2_pos,
   input wire logic lane3_pos,
   input wire logic lane0_neg,
   input wire logic lane1_neg,
   input wire logic lane2_neg,
   input wire logic lane3_neg,
   input wire logic fwd_clock_pos,
   input wire logic fwd_clock_neg,
   input wire logic lane0_oe,
   input wire logic lane1_oe,
   input wire logic lane2_oe,
   input wire logic lane3_oe,
   input wire logic fwd_clock_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // Filter and sync latency fit inside five ref_clk cycles
   sequence s_off; !power_down_n [*5]; endsequence
   sequence s_run; !fwd_clock_pos [*3] ##1 fwd_clock_pos [*4]; endsequence
   AST_LANE_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_off |-> !(lane0_oe | lane1_oe | lane2_oe | lane3_oe))
      else $error("lane driven while off");
   AST_CLK_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_off |-> !fwd_clock_oe) else $error("clock driven while off");
   AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_off |-> !(lane0_pos | lane1_pos | lane2_pos | lane3_pos
      | fwd_clock_pos)) else $error("state not cleared");
   AST_OE_UP: assert property (@(posedge ref_clk) disable iff (!nrst)
      power_down_n [*8] |-> fwd_clock_oe) else $error("no restart");
   // Disabled drivers must also show no shifting activity
   AST_OE_SAME: assert property (@(posedge link_clk) disable iff (!nrst)
      fwd_clock_oe == (lane0_oe & lane1_oe & lane2_oe & lane3_oe)
      && (fwd_clock_oe || !(lane0_pos | lane1_pos | lane2_pos | lane3_pos
      | fwd_clock_pos)))
      else $error("enables differ or activity while off");
   AST_FWD_PAT: assert property (@(posedge link_clk)
      disable iff (!nrst || !power_down_n)
      $fell(fwd_clock_pos) && fwd_clock_oe |-> s_run)
      else $error("clock lane pattern");
   AST_NEG_INV: assert property (@(posedge link_clk) disable iff (!nrst)
      (lane0_oe & lane1_oe & lane2_oe & lane3_oe) |->
      (lane0_neg != lane0_pos) && (lane1_neg != lane1_pos)
      && (lane2_neg != lane2_pos) && (lane3_neg != lane3_pos))
      else $error("lane not diff");
   AST_CLK_INV: assert property (@(posedge link_clk) disable iff (!nrst)
      fwd_clock_oe |-> fwd_clock_neg != fwd_clock_pos)
      else $error("clock not diff");
endmodule

// ### tb/pxs_rx_model.sv
// Purpose: Panel receiver. Assumes: bits LSB first. Notes: framed by clock.
module pxs_rx_model (
   input  wire logic        link_clk,
   input  wire logic [4:0]  pins,
   input  wire logic        oe,
   output logic      [27:0] word,
   output logic             got
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] sh [5];
   logic [6:0] nx [5];
   always_comb for (int k = 0; k < 5; k++) nx[k] = {pins[k], sh[k][6:1]};
   // Lane 3 kept although an 18-bit panel may leave it open
   always @(posedge link_clk) begin
      for (int k = 0; k < 5; k++) sh[k] <= nx[k];
      got <= oe && nx[4] == 7'h63;
      if (oe && nx[4] == 7'h63) word <= {nx[3], nx[2], nx[1], nx[0]};
   end
endmodule

// ### tb/tb.sv
// Purpose: Bench. Assumes: pixel period 7 link cycles. Notes: self-checking.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, link_clk = 0, nrst = 0, power_down_n = 1;
   logic capture_edge_select = 1, pixel_clock_in = 0, pclk_run = 0, got;
   logic [27:0] parallel_pixel_bits = '0, rx_word;
   logic [27:0] rxq [$];
   wire  [4:0]  pos, oe;
   int          pc = 0, n_errors = 0, checked = 0;
   always #25 ref_clk = ~ref_clk;
   always #3 link_clk = ~link_clk;
   always @(posedge link_clk) begin
      if (got === 1'b1) rxq.push_back(rx_word);
      if (pclk_run) begin
         pc = (pc + 1) % 7;
         pixel_clock_in <= #1 (pc < 4);
      end
   end
   pxs_top DUT (.ref_clk(ref_clk), .nrst(nrst), .link_clk(link_clk),
      .power_down_n(power_down_n), .capture_edge_select(capture_edge_select),
      .pixel_clock_in(pixel_clock_in),
      .parallel_pixel_bits(parallel_pixel_bits),
      .lane0_pos(pos[0]), .lane0_neg(), .lane0_oe(oe[0]),
      .lane1_pos(pos[1]), .lane1_neg(), .lane1_oe(oe[1]),
      .lane2_pos(pos[2]), .lane2_neg(), .lane2_oe(oe[2]),
      .lane3_pos(pos[3]), .lane3_neg(), .lane3_oe(oe[3]),
      .fwd_clock_pos(pos[4]), .fwd_clock_neg(), .fwd_clock_oe(oe[4]));
   pxs_rx_model u_rx (.link_clk(link_clk), .pins(pos), .oe(oe[4]),
      .word(rx_word), .got(got));
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic lk(input int n);
      repeat (n) @(posedge link_clk);
      #1;
   endtask
   task automatic t_stream(input logic sel, input logic [27:0] msk);
      logic [27:0] sent [$];
      int i0;
      lk(1);
      rxq.delete();
      capture_edge_select = sel;
      pclk_run = 1;
      // New word on the edge that does not capture
      for (int n = 0; n < 6; n++) begin
         wait (pixel_clock_in === sel);
         wait (pixel_clock_in !== sel);
         parallel_pixel_bits = (28'h9b3c5a7 ^ (n * 28'h1111111)) & msk;
         sent.push_back(parallel_pixel_bits);
      end
      lk(40);
      pclk_run = 0;
      i0 = -1;
      foreach (rxq[i]) if (rxq[i] === sent[1] && i0 < 0) i0 = i;
      chk(i0 >= 0, "word lost");
      for (int k = 2; k < 6; k++)
         chk(i0 >= 0 && rxq[i0+k-1] === sent[k], "word order");
   endtask
   task automatic t_edge(input logic sel);
      lk(1);
      capture_edge_select = sel;
      lk(10);
      pixel_clock_in = !sel;
      parallel_pixel_bits = 28'h5a5a5a5;
      lk(10);
      pixel_clock_in = sel;
      lk(10);
      parallel_pixel_bits = 28'ha5a5a5a;
      lk(10);
      pixel_clock_in = !sel;
      lk(30);
      chk(rxq.size() > 0 && rxq[$] === 28'h5a5a5a5, "edge select");
   endtask
   task automatic t_off;
      @(posedge ref_clk);
      #1 power_down_n = 0;
      repeat (12) @(posedge ref_clk);
      #1;
      chk(oe === 5'h00, "outputs driven");
      chk(pos === 5'h00, "state kept");
      power_down_n = 1;
      repeat (12) @(posedge ref_clk);
      #1;
      chk(oe === 5'h1f, "no restart");
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 nrst = 1;
      repeat (12) @(posedge ref_clk);
      t_stream(1'b1, 28'hfffffff);
      t_stream(1'b0, 28'h7fff3dd);
      t_edge(1'b1);
      t_edge(1'b0);
      t_off();
      t_stream(1'b1, 28'hfffffff);
      results();
   end
   initial begin
      #200us;
      n_errors++;
      results();
   end
endmodule
bind pxs_top pxs_properties u_props (.ref_clk(ref_clk), .nrst(nrst),
   .link_clk(link_clk), .power_down_n(power_down_n),
   .lane0_pos(lane0_pos), .lane1_pos(lane1_pos), .lane2_pos(lane2_pos),
   .lane3_pos(lane3_pos), .lane0_neg(lane0_neg),
   .lane1_neg(lane1_neg), .lane2_neg(lane2_neg), .lane3_neg(lane3_neg),
   .fwd_clock_pos(fwd_clock_pos), .fwd_clock_neg(fwd_clock_neg),
   .lane0_oe(lane0_oe), .lane1_oe(lane1_oe), .lane2_oe(lane2_oe),
   .lane3_oe(lane3_oe), .fwd_clock_oe(fwd_clock_oe));
